// ### src/tcm_pkg.sv
// shared constants and types for the timer channel block
package tcm_pkg;

    // ----------------------------------------------------------------
    // register map (byte offsets on the apb bus)
    // ----------------------------------------------------------------
    localparam logic [7:0] TCM_OFS_CTRL      = 8'h00; // mode and enable bits
    localparam logic [7:0] TCM_OFS_MODULO    = 8'h04; // counter end value
    localparam logic [7:0] TCM_OFS_VAL_HIGH  = 8'h08; // channel_value_high
    localparam logic [7:0] TCM_OFS_VAL_LOW   = 8'h0C; // channel_value_low
    localparam logic [7:0] TCM_OFS_STATUS    = 8'h10; // sticky events, read clears
    localparam logic [7:0] TCM_OFS_MASK      = 8'h14; // interrupt mask
    localparam logic [7:0] TCM_OFS_COUNT     = 8'h18; // live counter, read only

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int TCM_CTRL_EL_LSB = 0;  // edge_level_field [1:0]
    localparam int TCM_CTRL_MS_LSB = 2;  // channel_mode_field [3:2]
    localparam int TCM_CTRL_CENTER_ALIGN_SELECT  = 4;  // center_align_select
    localparam int TCM_CTRL_RUN    = 5;  // counter enable
    localparam int TCM_CTRL_WIDTH  = 6;
    localparam int TCM_STAT_CHAN   = 0;  // capture or compare event
    localparam int TCM_STAT_OVF    = 1;  // counter wrap or turn at zero
    localparam int TCM_STAT_WIDTH  = 2;
    localparam int TCM_CNT_WIDTH   = 16;

    localparam logic [TCM_CTRL_WIDTH-1:0] TCM_CTRL_RESET   = 6'h00;
    localparam logic [TCM_CNT_WIDTH-1:0]  TCM_MODULO_RESET = 16'hFFFF;
    localparam logic [TCM_CNT_WIDTH-1:0]  TCM_VALUE_RESET  = 16'h0000;
    localparam logic [TCM_STAT_WIDTH-1:0] TCM_STAT_RESET   = 2'h0;

    // ----------------------------------------------------------------
    // field encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] TCM_EL_NONE   = 2'h0;
    localparam logic [1:0] TCM_EL_RISE   = 2'h1; // also toggle in compare
    localparam logic [1:0] TCM_EL_FALL   = 2'h2; // also clear / high-true
    localparam logic [1:0] TCM_EL_BOTH   = 2'h3; // also set
    localparam logic [1:0] TCM_MS_CAPT   = 2'h0;
    localparam logic [1:0] TCM_MS_COMP   = 2'h1;

    // channel operating mode, one-hot
    typedef enum logic [4:0] {
        TCM_MODE_UNUSED  = 5'h01,
        TCM_MODE_CAPTURE = 5'h02,
        TCM_MODE_COMPARE = 5'h04,
        TCM_MODE_EPWM    = 5'h08,
        TCM_MODE_CPWM    = 5'h10
    } tcm_mode_t;

endpackage

// ### src/tcm_edge_detect.sv
// pin edge detector for input capture
`timescale 1ns/1ps
module tcm_edge_detect
    import tcm_pkg::*;
(
    input  wire logic clk,      // bus clock
    input  wire logic sys_rst,  // synchronous reset, active high
    input  wire logic pinIn,    // channel pin level
    input  wire logic riseEn,   // report rising edges
    input  wire logic fallEn,   // report falling edges
    output logic      edgeSeen  // one-cycle pulse per qualified edge
);

    logic prevPin;  // pin level one clock earlier
    wire  isRise = pinIn & ~prevPin;
    wire  isFall = ~pinIn & prevPin;

    // ----------------------------------------------------------------
    // history and detection
    // ----------------------------------------------------------------
    // no spurious edge on entry
    // history runs in every mode, so a pin change before entering
    // capture mode is not seen as an edge; only later changes set the flag
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prevPin  <= 1'b0;
            edgeSeen <= 1'b0;
        end else begin
            prevPin  <= pinIn;
            edgeSeen <= (isRise & riseEn) | (isFall & fallEn);
        end
    end

    a_rise_only: assert property (@(posedge clk) disable iff (sys_rst)
        (riseEn && !fallEn && !$past(sys_rst) && $fell(pinIn)) |=> !edgeSeen)
        else $error("falling edge reported in rising-only capture");

    a_fall_only: assert property (@(posedge clk) disable iff (sys_rst)
        (fallEn && !riseEn && !$past(sys_rst) && $rose(pinIn)) |=> !edgeSeen)
        else $error("rising edge reported in falling-only capture");

    a_both_edges: assert property (@(posedge clk) disable iff (sys_rst)
        (fallEn && riseEn && !$past(sys_rst) && $changed(pinIn)) |=> edgeSeen)
        else $error("pin change missed in both-edge capture");

endmodule

// ### src/tcm_counter.sv
// free-running timer counter, edge or center aligned
`timescale 1ns/1ps
module tcm_counter
    import tcm_pkg::*;
(
    input  wire logic                     clk,        // bus clock
    input  wire logic                     sys_rst,    // synchronous reset
    input  wire logic                     run,        // count enable
    input  wire logic                     centerMode, // up then down
    input  wire logic [TCM_CNT_WIDTH-1:0] modulo,     // top value
    output logic      [TCM_CNT_WIDTH-1:0] count,      // counter value
    output logic                          countUp,    // direction
    output logic                          overflow    // one-cycle pulse
);

    localparam logic [TCM_CNT_WIDTH-1:0] ONE  = 16'h0001;
    localparam logic [TCM_CNT_WIDTH-1:0] ZERO = 16'h0000;

    wire atTop  = (count >= modulo);
    wire atZero = (count == ZERO);

    // ----------------------------------------------------------------
    // counting
    // ----------------------------------------------------------------
    // edge mode wraps at modulo; center mode turns at modulo and zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count    <= ZERO;
            countUp  <= 1'b1;
            overflow <= 1'b0;
        end else if (!run) begin
            overflow <= 1'b0;
        end else if (!centerMode) begin
            countUp  <= 1'b1;
            overflow <= atTop;
            count    <= atTop ? ZERO : count + ONE;
        end else if (countUp) begin
            // turn down at top; a zero modulo just holds
            overflow <= 1'b0;
            countUp  <= ~atTop;
            count    <= atTop ? (atZero ? ZERO : count - ONE) : count + ONE;
        end else begin
            overflow <= atZero;
            countUp  <= atZero;
            count    <= atZero ? (atTop ? ZERO : ONE) : count - ONE;
        end
    end

endmodule

// ### src/tcm_channel.sv
// timer channel with mode logic, value register and apb slave
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module tcm_channel
    import tcm_pkg::*;
(
    input  wire logic        clk,        // bus clock, 200 MHz
    input  wire logic        sys_rst,    // synchronous reset, active high
    input  wire logic        psel,       // apb select
    input  wire logic        penable,    // apb access phase
    input  wire logic        pwrite,     // apb direction
    input  wire logic [7:0]  paddr,      // apb byte address
    input  wire logic [31:0] pwdata,     // apb write data
    output logic      [31:0] prdata,     // apb read data
    output logic             pready,     // apb ready
    output logic             pslverr,    // apb error on unmapped address
    output logic             irq,        // level interrupt
    input  wire logic        chanPinIn,  // channel pin input level
    output logic             chanPinOut, // channel pin output level
    output logic             chanPinOe   // channel pin drive enable
);

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic [TCM_CTRL_WIDTH-1:0] ctrl;      // mode fields and run bit
    logic [TCM_CNT_WIDTH-1:0]  modulo;    // counter top
    logic [TCM_CNT_WIDTH-1:0]  chanValue; // channel value, both bytes
    logic [TCM_STAT_WIDTH-1:0] status;    // sticky event bits
    logic [TCM_STAT_WIDTH-1:0] mask;      // interrupt mask

    // ----------------------------------------------------------------
    // field decode
    // ----------------------------------------------------------------
    wire [1:0] edgeLevel  = ctrl[TCM_CTRL_EL_LSB +: 2];
    wire [1:0] chanMode   = ctrl[TCM_CTRL_MS_LSB +: 2];
    wire       centerSel  = ctrl[TCM_CTRL_CENTER_ALIGN_SELECT];
    wire       cntRun     = ctrl[TCM_CTRL_RUN];

    // mode from center_align_select, channel_mode_field, edge_level_field
    function automatic tcm_mode_t decode_mode(input logic cs, input logic [1:0] ms,
                                              input logic [1:0] el);
        tcm_mode_t m;
        m = TCM_MODE_UNUSED;
        if (cs) begin
            m = (el == TCM_EL_NONE) ? TCM_MODE_UNUSED : TCM_MODE_CPWM;
        end else if (ms == TCM_MS_CAPT) begin
            m = (el == TCM_EL_NONE) ? TCM_MODE_UNUSED : TCM_MODE_CAPTURE;
        end else if (ms == TCM_MS_COMP) begin
            // compare with 00 still flags matches, pin left alone
            m = TCM_MODE_COMPARE;
        end else begin
            m = (el == TCM_EL_NONE) ? TCM_MODE_UNUSED : TCM_MODE_EPWM;
        end
        return m;
    endfunction

    wire tcm_mode_t chanModeSel = decode_mode(centerSel, chanMode, edgeLevel);
    wire isCapture = (chanModeSel == TCM_MODE_CAPTURE);
    wire isCompare = (chanModeSel == TCM_MODE_COMPARE);
    wire isEpwm    = (chanModeSel == TCM_MODE_EPWM);
    wire isCpwm    = (chanModeSel == TCM_MODE_CPWM);
    // X1 gives low-true pulses in both pwm modes
    wire lowTrue   = edgeLevel[0];

    // ----------------------------------------------------------------
    // counter and edge detector
    // ----------------------------------------------------------------
    logic [TCM_CNT_WIDTH-1:0] count;    // timer counter
    logic                     countUp;  // counter direction
    logic                     overflow; // counter period event
    logic                     edgeSeen; // qualified pin edge

    tcm_counter u_counter (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .run        (cntRun),
        .centerMode (centerSel),
        .modulo     (modulo),
        .count      (count),
        .countUp    (countUp),
        .overflow   (overflow)
    );

    tcm_edge_detect u_edge (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .pinIn    (chanPinIn),
        .riseEn   (isCapture & edgeLevel[0]),
        .fallEn   (isCapture & edgeLevel[1]),
        .edgeSeen (edgeSeen)
    );

    wire matchNow   = cntRun & (count == chanValue);
    wire periodTop  = cntRun & (count == TCM_VALUE_RESET);
    // capture only while still in capture mode when the edge lands
    wire captureNow = edgeSeen & isCapture;
    wire chanEvent  = isCapture ? captureNow : (matchNow & ~isCapture & (chanModeSel != TCM_MODE_UNUSED));

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    // one wait state: pready rises in the second access cycle, so prdata
    // can be loaded from a flop; writes commit on the pready edge
    wire accessFirst = psel & penable & ~pready;
    wire commit      = psel & penable & pready;
    wire hitCtrl     = (paddr == TCM_OFS_CTRL);
    wire hitModulo   = (paddr == TCM_OFS_MODULO);
    wire hitHigh     = (paddr == TCM_OFS_VAL_HIGH);
    wire hitLow      = (paddr == TCM_OFS_VAL_LOW);
    wire hitStatus   = (paddr == TCM_OFS_STATUS);
    wire hitMask     = (paddr == TCM_OFS_MASK);
    wire hitCount    = (paddr == TCM_OFS_COUNT);
    wire mapped      = hitCtrl | hitModulo | hitHigh | hitLow | hitStatus | hitMask | hitCount;
    wire wrCommit    = commit & pwrite & mapped;
    wire rdStatus    = commit & ~pwrite & hitStatus;

    // read mux, narrower registers sit in the low bits
    wire [31:0] readMux =
        hitCtrl   ? {26'h0000000, ctrl} :
        hitModulo ? {16'h0000, modulo} :
        hitHigh   ? {24'h000000, chanValue[15:8]} :
        hitLow    ? {24'h000000, chanValue[7:0]} :
        hitStatus ? {30'h00000000, status} :
        hitMask   ? {30'h00000000, mask} :
        hitCount  ? {16'h0000, count} : 32'h00000000;

    // status bits returned by the pending read; only those get cleared
    wire [TCM_STAT_WIDTH-1:0] readClear = rdStatus ? prdata[TCM_STAT_WIDTH-1:0] : TCM_STAT_RESET;
    wire [TCM_STAT_WIDTH-1:0] newEvents = {overflow, chanEvent};

    // ----------------------------------------------------------------
    // bus handshake
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= accessFirst;
            pslverr <= accessFirst & ~mapped;
            // hold data stable until the next read is answered
            if (accessFirst & ~pwrite) begin
                prdata <= readMux;
            end
        end
    end

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl   <= TCM_CTRL_RESET;
            modulo <= TCM_MODULO_RESET;
            mask   <= TCM_STAT_RESET;
        end else if (wrCommit) begin
            if (hitCtrl) begin
                ctrl <= pwdata[TCM_CTRL_WIDTH-1:0];
            end
            if (hitModulo) begin
                modulo <= pwdata[TCM_CNT_WIDTH-1:0];
            end
            if (hitMask) begin
                mask <= pwdata[TCM_STAT_WIDTH-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // channel value register
    // ----------------------------------------------------------------
    // value cleared by reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            chanValue <= TCM_VALUE_RESET;
        end else if (captureNow) begin
            // capture overrides a write in the same cycle
            chanValue <= count;
        end else if (wrCommit & hitHigh) begin
            chanValue[15:8] <= pwdata[7:0];
        end else if (wrCommit & hitLow) begin
            chanValue[7:0] <= pwdata[7:0];
        end
    end

    // ----------------------------------------------------------------
    // status and interrupt
    // ----------------------------------------------------------------
    // set wins: a new event in the clearing cycle survives
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            status <= TCM_STAT_RESET;
            irq    <= 1'b0;
        end else begin
            status <= (status & ~readClear) | newEvents;
            irq    <= |(((status & ~readClear) | newEvents) & mask);
        end
    end

    // ----------------------------------------------------------------
    // pin drive
    // ----------------------------------------------------------------
    logic next_pinOut; // pin level for next cycle
    logic next_pinOe;  // pin enable for next cycle

    always_comb begin
        next_pinOut = chanPinOut;
        next_pinOe  = 1'b0;
        case (chanModeSel)
            TCM_MODE_COMPARE: begin
                next_pinOe = (edgeLevel != TCM_EL_NONE);
                if (matchNow) begin
                    case (edgeLevel)
                        TCM_EL_RISE: next_pinOut = ~chanPinOut;
                        TCM_EL_FALL: next_pinOut = 1'b0;
                        TCM_EL_BOTH: next_pinOut = 1'b1;
                        default:     next_pinOut = chanPinOut;
                    endcase
                end
            end
            TCM_MODE_EPWM: begin
                next_pinOe = 1'b1;
                // match ends the active part, counter start begins it
                if (matchNow) begin
                    next_pinOut = lowTrue;
                end else if (periodTop) begin
                    next_pinOut = ~lowTrue;
                end
            end
            TCM_MODE_CPWM: begin
                next_pinOe = 1'b1;
                // up-match ends active part, down-match restarts it
                if (matchNow) begin
                    next_pinOut = countUp ? lowTrue : ~lowTrue;
                end
            end
            TCM_MODE_CAPTURE: begin
                next_pinOe = 1'b0;
            end
            TCM_MODE_UNUSED: begin
                next_pinOe = 1'b0;
            end
            default: begin
                next_pinOe = 1'b0;
            end
        endcase
    end

    // pin registers, so the pin never glitches on decode changes
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            chanPinOut <= 1'b0;
            chanPinOe  <= 1'b0;
        end else begin
            chanPinOut <= next_pinOut;
            chanPinOe  <= next_pinOe;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_unused_pin_off: assert property (@(posedge clk) disable iff (sys_rst)
        (edgeLevel == TCM_EL_NONE) |=> !chanPinOe)
        else $error("pin driven while edge/level is 00");

    a_compare_toggle: assert property (@(posedge clk) disable iff (sys_rst)
        (isCompare && edgeLevel == TCM_EL_RISE && matchNow) |=> (chanPinOut != $past(chanPinOut)) && chanPinOe)
        else $error("compare toggle did not toggle pin");

    a_compare_clear: assert property (@(posedge clk) disable iff (sys_rst)
        (isCompare && edgeLevel == TCM_EL_FALL && matchNow) |=> !chanPinOut && chanPinOe)
        else $error("compare clear did not drive low");

    a_compare_set: assert property (@(posedge clk) disable iff (sys_rst)
        (isCompare && edgeLevel == TCM_EL_BOTH && matchNow) |=> chanPinOut && chanPinOe)
        else $error("compare set did not drive high");

    a_edge_pwm_high: assert property (@(posedge clk) disable iff (sys_rst)
        (isEpwm && edgeLevel == TCM_EL_FALL && matchNow) |=> !chanPinOut)
        else $error("edge pwm high-true not cleared on match");

    a_edge_pwm_low: assert property (@(posedge clk) disable iff (sys_rst)
        (isEpwm && lowTrue && matchNow) |=> chanPinOut)
        else $error("edge pwm low-true not set on match");

    a_center_pwm_high: assert property (@(posedge clk) disable iff (sys_rst)
        (centerSel && edgeLevel == TCM_EL_FALL && matchNow && countUp) |=> !chanPinOut && chanPinOe)
        else $error("center pwm high-true not cleared on up-match");

    a_center_pwm_low: assert property (@(posedge clk) disable iff (sys_rst)
        (centerSel && lowTrue && matchNow && countUp) |=> chanPinOut && chanPinOe)
        else $error("center pwm low-true not set on up-match");

    a_value_reset: assert property (@(posedge clk)
        $past(sys_rst) |-> (chanValue == TCM_VALUE_RESET))
        else $error("channel value not cleared by reset");

    a_capture_copy: assert property (@(posedge clk) disable iff (sys_rst)
        captureNow |=> (chanValue == $past(count)) && status[TCM_STAT_CHAN])
        else $error("capture did not copy counter and flag");

endmodule

// ### verif/tcm_pin_model.sv
// far-side pin model for the timer channel
`timescale 1ns/1ps
module tcm_pin_model (
    input  wire logic drvOut,   // channel output level
    input  wire logic drvOe,    // channel drive enable
    input  wire logic extLevel, // level of the outside source
    output logic      pinLevel  // resolved pin level
);
    // channel wins while it drives, else the outside source sets the wire
    assign pinLevel = drvOe ? drvOut : extLevel;
endmodule

// ### verif/testbench.sv
// self-checking bench for the timer channel
`timescale 1ns/1ps
module testbench;
    import tcm_pkg::*;
    logic        clk, sys_rst, psel, penable, pwrite, ext, pready, pslverr, irq, pOut, pOe, pin;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, seed;
    int          errors, comparisons, hi;
    logic [64:0] expQ[$]; // error flag, expected data, compare mask
    // ctrl, window length, expected high cycles
    logic [31:0] pw[4] = '{32'h002A2105, 32'h0029211C, 32'h0032400A, 32'h00314036};

    tcm_channel tcm_channel_inst (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .chanPinIn(pin), .chanPinOut(pOut), .chanPinOe(pOe));
    tcm_pin_model tcm_pin_model_inst (.drvOut(pOut), .drvOe(pOe), .extLevel(ext), .pinLevel(pin));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask

    // one apb transfer; for reads d is the expected value, harmless on pwdata
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                        input logic err);
        expQ.push_back({err, d, m});
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // count cycles with the pin high
    task automatic cnt(input int n);
        hi = 0;
        repeat (n) begin
            @(posedge clk);
            hi += (pOut === 1'b1);
        end
    endtask

    task automatic stop_test();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // answer monitor: oldest note against each completed transfer
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1) begin
            chk("prdata", expQ[0][63:32] & expQ[0][31:0], prdata & expQ[0][31:0]);
            chk("pslverr", 32'(expQ[0][64]), 32'(pslverr));
            void'(expQ.pop_front());
        end
    end

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // watchdog, far beyond the expected run of about 1300 cycles
    initial begin
        #60000;
        errors++;
        stop_test();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {sys_rst, psel, penable, pwrite, ext, paddr, pwdata} = '0;
        sys_rst = 1'b1;
        seed = 32'h4b47;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        xfer(1'b0, TCM_OFS_VAL_HIGH, 32'h0, 32'hFF, 1'b0);
        xfer(1'b0, TCM_OFS_VAL_LOW, 32'h0, 32'hFF, 1'b0);
        xfer(1'b0, 8'h1C, 32'h0, 32'hFFFFFFFF, 1'b1); // unmapped place
        seed = xs(seed);
        xfer(1'b1, TCM_OFS_VAL_HIGH, seed, 32'h0, 1'b0);
        xfer(1'b0, TCM_OFS_VAL_HIGH, seed, 32'hFF, 1'b0);
        xfer(1'b1, TCM_OFS_MODULO, 32'h20, 32'h0, 1'b0);
        // capture with each edge selection, flags cleared after each change
        for (int el = 0; el < 4; el++) begin
            xfer(1'b1, TCM_OFS_CTRL, 32'h20 | el, 32'h0, 1'b0);
            repeat (4) @(posedge clk);
            xfer(1'b0, TCM_OFS_STATUS, 32'h0, 32'h0, 1'b0);
            ext <= 1'b1;
            repeat (4) @(posedge clk);
            xfer(1'b0, TCM_OFS_STATUS, el & 1, 32'h1, 1'b0);
            ext <= 1'b0;
            repeat (4) @(posedge clk);
            xfer(1'b0, TCM_OFS_STATUS, el >> 1, 32'h1, 1'b0);
            chk("oe", 32'h0, 32'(pOe));
        end
        xfer(1'b1, TCM_OFS_VAL_HIGH, 32'h0, 32'h0, 1'b0);
        xfer(1'b1, TCM_OFS_VAL_LOW, 32'h5, 32'h0, 1'b0);
        xfer(1'b1, TCM_OFS_MASK, 32'h1, 32'h0, 1'b0);
        // output compare: set, clear, toggle, software only
        for (int el = 3; el >= 0; el--) begin
            xfer(1'b1, TCM_OFS_CTRL, 32'h24 | el, 32'h0, 1'b0);
            repeat (40) @(posedge clk);
            chk("oe", el != 0, 32'(pOe));
            if (el > 1) chk("pin", el & 1, 32'(pOut));
            hi = pOut;
            repeat (33) @(posedge clk);
            if (el == 1) chk("toggle", hi ^ 1, 32'(pOut));
        end
        // stop the counter so no new event races the interrupt checks
        xfer(1'b1, TCM_OFS_CTRL, 32'h04, 32'h0, 1'b0);
        xfer(1'b0, TCM_OFS_CTRL, 32'h04, 32'h3F, 1'b0);
        repeat (2) @(posedge clk);
        chk("irq", 32'h1, 32'(irq));
        xfer(1'b1, TCM_OFS_MASK, 32'h0, 32'h0, 1'b0);
        repeat (2) @(posedge clk);
        chk("irq", 32'h0, 32'(irq));
        xfer(1'b1, TCM_OFS_MASK, 32'h1, 32'h0, 1'b0);
        // counter wrapped many times since the last status read, so both bits stand
        xfer(1'b0, TCM_OFS_STATUS, 32'h3, 32'h3, 1'b0);
        repeat (2) @(posedge clk);
        chk("irq", 32'h0, 32'(irq));
        // pwm duty over one full period, edge then center aligned
        foreach (pw[i]) begin
            xfer(1'b1, TCM_OFS_CTRL, 32'(pw[i][31:16]), 32'h0, 1'b0);
            repeat (140) @(posedge clk);
            cnt(pw[i][15:8]);
            chk("duty", 32'(pw[i][7:0]), hi);
        end
        // reset again mid-run: value and modulo must fall back to reset
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        xfer(1'b0, TCM_OFS_VAL_LOW, 32'h0, 32'hFF, 1'b0);
        xfer(1'b0, TCM_OFS_MODULO, 32'hFFFF, 32'hFFFF, 1'b0);
        chk("oe", 32'h0, 32'(pOe));
        stop_test();
    end
endmodule
